// [flash_wp_logic.sv]
// Write enable latch and protection gating of a serial flash
// Summary of operation
// [R1] Complete 06h with byte-aligned release sets the write enable latch.
// [R2] Program, erase and status writes need the latch set beforehand.
// [R3] Release off a byte boundary aborts enable/disable, latch unchanged.
// [R4] Complete 04h with byte-aligned release clears the write enable latch.
// [R5] Six protection bits change only by status-register write.
// [R6] Normal mode protects 1/64 to 1/2, top or bottom end.
// [R7] Fine mode protects 4 to 32 KB; 000 none, 111 all.
// [R8] Complement bit inverts the protected set.
// [R9] Write-protect pin never alters the range directly.
// [R10] Write-protect low blocks every protection-bit update.
// [R11] Protected erase or uneven release clears latch, no operation.
// [R12] Completed program, erase or status write clears the latch.
`timescale 1ns/1ns
module flash_wp_logic #(
  parameter int AW = flash_wp_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic          i_clk_sys,
  input  wire logic          i_sys_rst,
  // Serial pins
  input  wire logic          i_spi_sck,
  input  wire logic          i_spi_cs_n,
  input  wire logic          i_spi_mosi,
  input  wire logic          i_wp_n,
  // Array engine handshake
  input  wire logic          i_op_done,
  output logic               o_op_start,
  output logic [7:0]         o_op_code,
  output logic [AW-1:0]      o_op_addr,
  // Status
  output logic               o_write_enable_latch,
  output logic [5:0]         o_prot_bits,
  output logic               o_cmd_rejected
);
  // Two-stage synchronisers for pins
  logic [1:0] sck_s_q;
  logic [1:0] cs_s_q;
  logic [1:0] mosi_s_q;
  logic [1:0] wp_s_q;
  logic       sck_prev_q;
  logic       cs_prev_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      sck_s_q    <= 2'h0;
      cs_s_q     <= 2'h3;
      mosi_s_q   <= 2'h0;
      wp_s_q     <= 2'h0;
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end else begin
      sck_s_q    <= {sck_s_q[0], i_spi_sck};
      cs_s_q     <= {cs_s_q[0], i_spi_cs_n};
      mosi_s_q   <= {mosi_s_q[0], i_spi_mosi};
      wp_s_q     <= {wp_s_q[0], i_wp_n};
      sck_prev_q <= sck_s_q[1];
      cs_prev_q  <= cs_s_q[1];
    end
  end

  logic sck_rise;
  logic cs_active;
  logic cs_release;
  logic wp_high;
  assign sck_rise   = sck_s_q[1] & ~sck_prev_q;
  assign cs_active  = ~cs_s_q[1];
  assign cs_release = cs_s_q[1] & ~cs_prev_q;
  assign wp_high    = wp_s_q[1];

  // Frame shifter: opcode, three address bytes, one status byte
  logic [7:0]    shift_q;
  logic [2:0]    bit_cnt_q;
  logic [2:0]    byte_cnt_q;
  logic [7:0]    opcode_q;
  logic [AW-1:0] addr_q;
  logic [7:0]    data_q;
  logic [7:0]    shift_d;
  logic          byte_end;
  assign shift_d  = {shift_q[6:0], mosi_s_q[1]};
  assign byte_end = sck_rise && cs_active && (bit_cnt_q == 3'h7);

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !cs_active) begin
      shift_q    <= 8'h00;
      bit_cnt_q  <= 3'h0;
      byte_cnt_q <= 3'h0;
    end else if (sck_rise) begin
      shift_q   <= shift_d;
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (byte_end && byte_cnt_q != 3'h7) begin
        byte_cnt_q <= byte_cnt_q + 3'h1;
      end
    end
  end

  // Captured fields keep their value through the release
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      opcode_q <= 8'h00;
      addr_q   <= '0;
      data_q   <= 8'h00;
    end else if (byte_end) begin
      unique case (byte_cnt_q)
        3'h0: opcode_q <= shift_d;
        3'h1: begin
          // Top two bits of the first address byte lie beyond the array
          addr_q[AW-1:16] <= shift_d[AW-17:0];
          data_q          <= shift_d;
        end
        3'h2: addr_q[15:8] <= shift_d;
        3'h3: addr_q[7:0]  <= shift_d;
        // Later bytes are payload and leave the captured fields alone
        default: ;
      endcase
    end
  end

  // Release decode
  logic aligned;
  logic have_op;
  logic is_we;
  logic is_wd;
  logic is_wrsr;
  logic is_chip;
  logic is_addr_op;
  logic gated;
  logic addr_ok;
  logic target_prot;
  logic rel_ok;
  logic [5:0] prot_q;

  assign aligned    = (bit_cnt_q == 3'h0);
  assign have_op    = (byte_cnt_q != 3'h0);
  assign rel_ok     = cs_release && aligned && have_op;
  assign is_we      = opcode_q == flash_wp_pkg::OP_WRITE_ENABLE;
  assign is_wd      = opcode_q == flash_wp_pkg::OP_WRITE_DISABLE;
  assign is_wrsr    = opcode_q == flash_wp_pkg::OP_WRITE_STATUS;
  assign is_chip    = opcode_q == flash_wp_pkg::OP_CHIP_ERASE_A ||
                      opcode_q == flash_wp_pkg::OP_CHIP_ERASE_B;
  assign is_addr_op = opcode_q == flash_wp_pkg::OP_PAGE_PROGRAM  ||
                      opcode_q == flash_wp_pkg::OP_SECTOR_ERASE  ||
                      opcode_q == flash_wp_pkg::OP_BLOCK32_ERASE ||
                      opcode_q == flash_wp_pkg::OP_BLOCK64_ERASE ||
                      opcode_q == flash_wp_pkg::OP_SEC_PROGRAM   ||
                      opcode_q == flash_wp_pkg::OP_SEC_ERASE;
  assign gated      = is_wrsr || is_chip || is_addr_op;
  // Address ops need all three address bytes; extra payload bytes are allowed
  assign addr_ok    = !is_addr_op || (byte_cnt_q >= 3'h4);
  // Chip erase is blocked if any part is protected: check both ends
  logic prot_lo;
  logic prot_hi;
  flash_wp_range #(
    .AW (AW)
  ) u_range_addr (
    .i_prot      (prot_q),
    .i_addr      (addr_q),
    .o_protected (prot_lo)
  );
  flash_wp_range #(
    .AW (AW)
  ) u_range_top (
    .i_prot      (prot_q),
    .i_addr      ('1),
    .o_protected (prot_hi)
  );
  // Chip erase: any protection at either end suffices for typical layouts
  logic prot_any;
  logic [AW-1:0] zero_addr;
  assign zero_addr = '0;
  flash_wp_range #(
    .AW (AW)
  ) u_range_bot (
    .i_prot      (prot_q),
    .i_addr      (zero_addr),
    .o_protected (prot_any)
  );
  assign target_prot = is_chip ? (prot_hi | prot_any) : prot_lo;

  logic launch;
  logic status_write;
  logic wel_q;
  logic busy_q;
  assign launch = rel_ok && gated && wel_q && addr_ok && !busy_q &&
                  !(target_prot && !is_wrsr);                      // R2 R11
  // Status write with the pin low still completes without a reject pulse but leaves the bits unchanged
  assign status_write = launch && is_wrsr && wp_high && byte_cnt_q >= 3'h2;

  // Write enable latch
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      wel_q <= 1'b0;
    end else if (rel_ok && is_we && !busy_q) begin
      wel_q <= 1'b1;                                               // R1 R3
    end else if (rel_ok && is_wd && !busy_q) begin
      wel_q <= 1'b0;                                               // R4 R3
    end else if (cs_release && gated && have_op && !launch) begin
      wel_q <= 1'b0;                                               // R11
    end else if (launch && is_wrsr) begin
      // Status write has no busy phase: it completes at the release
      wel_q <= 1'b0;                                               // R12
    end else if (busy_q && i_op_done) begin
      wel_q <= 1'b0;                                               // R12
    end
  end

  // Protection bits: only a status write with the pin high updates them
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      prot_q <= flash_wp_pkg::PROT_RESET;
    end else if (status_write) begin
      prot_q <= data_q[5:0];                                       // R5 R9 R10
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      busy_q         <= 1'b0;
      o_op_start     <= 1'b0;
      o_op_code      <= 8'h00;
      o_op_addr      <= '0;
      o_cmd_rejected <= 1'b0;
    end else begin
      o_op_start     <= launch && !is_wrsr;
      o_cmd_rejected <= cs_release && gated && have_op && !launch;
      if (launch && !is_wrsr) begin
        busy_q    <= 1'b1;
        o_op_code <= opcode_q;
        o_op_addr <= addr_q;
      end else if (i_op_done) begin
        busy_q <= 1'b0;
      end
    end
  end

  assign o_write_enable_latch = wel_q;
  assign o_prot_bits          = prot_q;
endmodule

// [flash_wp_pkg.sv]
// Constants for the flash write-protection logic
package flash_wp_pkg;
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
  localparam logic [7:0] OP_PAGE_PROGRAM  = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE  = 8'h20;
  localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A  = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B  = 8'hC7;
  localparam logic [7:0] OP_SEC_PROGRAM   = 8'h42;
  localparam logic [7:0] OP_SEC_ERASE     = 8'h44;
  localparam int         ADDR_W           = 22;
  localparam int         BITS_PER_BYTE    = 8;
  localparam logic [5:0] PROT_RESET       = 6'h00;
  // Field positions inside the six protection bits
  localparam int PB_LO   = 0;
  localparam int PB_MID  = 1;
  localparam int PB_HI   = 2;
  localparam int PB_TB   = 3;
  localparam int PB_SEC  = 4;
  localparam int PB_CMP  = 5;
  // Smallest fine region and smallest coarse region, as address bit counts
  localparam int FINE_SHIFT   = 12;
  localparam int COARSE_SHIFT = 16;
endpackage

// [flash_wp_range.sv]
// Protected range decoder for the six protection bits
`timescale 1ns/1ns
module flash_wp_range #(
  parameter int AW = flash_wp_pkg::ADDR_W
) (
  // Protection settings
  input  wire logic [5:0]    i_prot,
  // Address to check
  input  wire logic [AW-1:0] i_addr,
  output logic               o_protected
);
  logic [2:0]    bp;
  logic          fine;
  logic          bottom;
  logic          cmp;
  logic [4:0]    shift;
  logic [AW-1:0] span;
  logic          in_region;
  logic          base_prot;

  assign bp     = {i_prot[flash_wp_pkg::PB_HI], i_prot[flash_wp_pkg::PB_MID],
                   i_prot[flash_wp_pkg::PB_LO]};
  assign fine   = i_prot[flash_wp_pkg::PB_SEC];
  assign bottom = i_prot[flash_wp_pkg::PB_TB];
  assign cmp    = i_prot[flash_wp_pkg::PB_CMP];

  // Fine mode saturates at 32 KB for 10x and 110
  assign shift = fine
    ? 5'(flash_wp_pkg::FINE_SHIFT) + ((bp > 3'h4) ? 5'h3 : 5'(bp - 3'h1))
    : 5'(flash_wp_pkg::COARSE_SHIFT) + 5'(bp - 3'h1);  // R6 R7
  assign span  = AW'(({{AW-1{1'b0}}, 1'b1} << shift) - 1'b1);

  // Top region: upper address bits above span are all ones
  assign in_region = bottom ? ((i_addr & ~span) == '0)
                            : ((i_addr | span) == '1);  // R6

  assign base_prot = (bp == 3'h0) ? 1'b0 :
                     (bp == 3'h7) ? 1'b1 : in_region;   // R7
  assign o_protected = base_prot ^ cmp;                 // R8
endmodule

// [flash_wp_host.sv]
// Serial host model that clocks command frames into the flash
`timescale 1ns/1ns
module flash_wp_host (
  // Serial pins
  output logic o_sck,
  output logic o_cs_n,
  output logic o_mosi
);
  initial begin
    o_sck  = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // Sends the top nb bits of d, MSB first, mode 0
  task automatic frame(input logic [31:0] d, input int nb);
    o_cs_n = 1'b0;
    for (int k = 0; k < nb; k++) begin
      o_mosi = d[31-k];
      #80 o_sck = 1'b1;
      #80 o_sck = 1'b0;
    end
    #80 o_cs_n = 1'b1;
    // Released line must not keep showing the last bit
    o_mosi = ~o_mosi;
    #400;
  endtask
endmodule

// [flash_wp_logic_sva.sv]
// Port assertions for the flash write-protection logic
`timescale 1ns/1ns
module flash_wp_logic_sva (
  // Clock and reset
  input wire logic       i_clk_sys,
  input wire logic       i_sys_rst,
  // Pins and handshake
  input wire logic       i_spi_cs_n,
  input wire logic       i_wp_n,
  input wire logic       i_op_done,
  input wire logic       o_op_start,
  input wire logic       o_write_enable_latch,
  input wire logic [5:0] o_prot_bits,
  input wire logic       o_cmd_rejected
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  property p_start_wel; o_op_start |-> $past(o_write_enable_latch); endproperty
  a_start_wel: assert property (p_start_wel) else $error("start, no wel");
  property p_prot_rel; $changed(o_prot_bits) |-> $past(i_spi_cs_n, 2); endproperty
  a_prot_rel: assert property (p_prot_rel) else $error("prot mid-frame");
  property p_prot_lock; $changed(o_prot_bits) |-> $past(i_wp_n, 3); endproperty
  a_prot_lock: assert property (p_prot_lock) else $error("prot locked");
  property p_wel_rise; $rose(o_write_enable_latch) |-> $past(i_spi_cs_n, 2);
  endproperty
  a_wel_rise: assert property (p_wel_rise) else $error("wel mid-frame");
  property p_start_pulse; o_op_start |=> !o_op_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start long");
  property p_rej_clr; o_cmd_rejected |-> ##[0:2] !o_write_enable_latch;
  endproperty
  a_rej_clr: assert property (p_rej_clr) else $error("wel after reject");
  property p_done_clr; i_op_done |=> !o_write_enable_latch; endproperty
  a_done_clr: assert property (p_done_clr) else $error("wel after done");
  property p_rej_one; o_cmd_rejected |-> !o_op_start ##1 !o_cmd_rejected;
  endproperty
  a_rej_one: assert property (p_rej_one) else $error("reject pulse");
endmodule
bind flash_wp_logic flash_wp_logic_sva flash_wp_logic_sva_i (.i_clk_sys,
  .i_sys_rst, .i_spi_cs_n, .i_wp_n, .i_op_done, .o_op_start,
  .o_write_enable_latch, .o_prot_bits, .o_cmd_rejected);

// [flash_wp_logic_test.sv]
// Self-checking bench for the flash write-protection logic
`timescale 1ns/1ns
module flash_wp_logic_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wp_n = 1'b1;
  logic        done = 1'b0;
  wire         sck, cs_n, mosi, start, write_enable_latch, rej;
  wire  [7:0]  code;
  wire  [21:0] addr;
  wire  [5:0]  prot;
  int          fail_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          n_st = 0;
  int          n_rj = 0;
  logic [5:0]  tp [14] = '{6'h01, 6'h01, 6'h09, 6'h09, 6'h11, 6'h11,
                           6'h21, 6'h21, 6'h07, 6'h27, 6'h14, 6'h16,
                           6'h0E, 6'h01};
  logic [21:0] ta [14] = '{22'h3F0000, 22'h3EF000, 22'h00F000, 22'h010000,
                           22'h3FF000, 22'h3FE000, 22'h3F0000, 22'h000000,
                           22'h000000, 22'h000000, 22'h3F8000, 22'h3F7000,
                           22'h200000, 22'h3EF000};
  logic        tok [14] = '{0, 1, 0, 1, 0, 1, 1, 0, 0, 1, 0, 1, 1, 1};
  always #10 clk = ~clk;
  flash_wp_host flash_wp_host_i (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi));
  flash_wp_logic flash_wp_logic_i (.i_clk_sys(clk), .i_sys_rst(rst),
    .i_spi_sck(sck), .i_spi_cs_n(cs_n), .i_spi_mosi(mosi), .i_wp_n(wp_n),
    .i_op_done(done), .o_op_start(start), .o_op_code(code),
    .o_op_addr(addr), .o_write_enable_latch(write_enable_latch), .o_prot_bits(prot),
    .o_cmd_rejected(rej));
  always @(posedge clk) begin
    cyc++;
    if (start === 1'b1) n_st++;
    if (rej === 1'b1) n_rj++;
    if (cyc == 40000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cmd(logic [31:0] d, int nb);
    @(posedge clk);
    #1 flash_wp_host_i.frame(d, nb);
  endtask
  // Gated op: counts launch and refusal pulses across the frame
  task automatic op(logic [31:0] d, logic ok);
    int s;
    int r;
    s = n_st;
    r = n_rj;
    cmd(d, 32);
    check("start", n_st - s, ok);
    check("reject", n_rj - r, !ok);
    check("wel", write_enable_latch, ok);
    if (ok) begin
      check("code", code, d[31:24]);
      check("addr", addr, d[21:0]);
      @(posedge clk) #1 done = 1'b1;
      @(posedge clk) #1 done = 1'b0;
      @(posedge clk) #1 check("wel", write_enable_latch, 0);
    end
  endtask
  task automatic t_latch;
    check("wel", write_enable_latch, 0);
    check("prot", prot, 0);
    cmd(32'h06000000, 8);
    check("wel", write_enable_latch, 1);
    cmd(32'h04FF0000, 16);
    check("wel", write_enable_latch, 0);
    cmd(32'h06000000, 7);
    check("wel", write_enable_latch, 0);
    cmd(32'h06000000, 12);
    check("wel", write_enable_latch, 0);
    cmd(32'h06000000, 8);
    cmd(32'h04000000, 12);
    check("wel", write_enable_latch, 1);
  endtask
  task automatic t_gate;
    cmd(32'h04000000, 8);
    op(32'h02123456, 0);
    cmd(32'h06000000, 8);
    op(32'h02123456, 1);
    cmd(32'h06000000, 8);
    cmd(32'h20000000, 20);
    check("wel", write_enable_latch, 0);
    cmd(32'h06000000, 8);
    op(32'h60000000, 1);
  endtask
  // Each entry: load protection bits, then erase one address
  task automatic t_table;
    for (int i = 0; i < 14; i++) begin
      cmd(32'h06000000, 8);
      cmd({8'h01, 2'h0, tp[i], 16'h0000}, 16);
      check("prot", prot, tp[i]);
      check("wel", write_enable_latch, 0);
      cmd(32'h06000000, 8);
      op({8'h20, 2'h0, ta[i]}, tok[i]);
    end
  endtask
  task automatic t_lock;
    @(posedge clk) #1 wp_n = 1'b0;
    cmd(32'h06000000, 8);
    cmd(32'h013F0000, 16);
    check("prot", prot, 6'h01);
    check("wel", write_enable_latch, 0);
    cmd(32'h06000000, 8);
    op(32'h203EF000, 1);
    cmd(32'h06000000, 8);
    op(32'h203F0000, 0);
    cmd(32'h06000000, 8);
    op(32'hC7000000, 0);
    @(posedge clk) #1 wp_n = 1'b1;
  endtask
  task automatic conclude;
    if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge clk);
    t_latch();
    t_gate();
    t_table();
    t_lock();
    conclude();
  end
endmodule
